/* File: sdri_top.sv */
// module: serial link, register map and reset control of the code front end

// Contract
// R1: shift 24-bit frames, link up to 50 MHz
// R2: works with free-running or gated link clock
// R3: frame starts at frame-select falling edge
// R4: link clock and data ignored while deselected
// R5: complete frame written on frame-select rise
// R6: host gives at least 24 falling edges
// R7: short frame clears shifter, changes nothing
// R8: low 16 bits code, upper byte command
// R9: code writes land in buffer register
// R10: mode 0 copies buffer to output at once
// R11: mode 1 holds output until load trigger
// R12: load trigger lives in register 5h
// R13: mode enable is bit 0 of 2h
// R14: output code register at 8h, 16 bits
// R15: reset loads zero or midscale by select
// R16: host waits 250 us after power-on
// R17: default output holds until valid write
// R18: reset pin low restores all defaults
// R19: host releases reset pin, waits 250 us
// R20: default follows select at pin assertion
// R21: key 1010 in 5h restarts like power-on
// R22: writes to 0h change nothing
// R23: load trigger is bit 4, self-clearing
// R24: reset key bits 3-0, self-clearing
// R25: code resets to 0000h or 8000h
// R26: bit 23 write flag, all frames writes
module sdri_top
   import sdri_pkg::*;
#(
   parameter int unsigned POR_WAIT = POR_WAIT_CYC
) (
   input  wire logic              clk_sys,
   input  wire logic              rst,
   input  wire logic              link_sclk,
   input  wire logic              frame_sel_n,
   input  wire logic              serial_data_in,
   input  wire logic              hw_reset_n,
   input  wire logic              reset_level_select,
   output logic      [DATA_W-1:0] code_out,
   output logic      [DATA_W-1:0] buffer_out,
   output logic                   update_mode,
   output logic                   link_ready,
   output logic                   frame_done,
   output logic                   frame_abort
);

   // ==========================================================
   // elaboration checks
   // ==========================================================
   if (POR_WAIT < 1 || POR_WAIT > (1 << WAIT_W)) begin : g_bad_wait
      $error("POR_WAIT out of range");
   end

   localparam logic [WAIT_W-1:0] WAIT_LAST = WAIT_W'(POR_WAIT - 1);

   // ==========================================================
   // helpers
   // ==========================================================
   // a pin level counts once the second and third stages agree
   function automatic logic sdri_filt(
      input logic [2:0] pipe,
      input logic       held
   );
      return (pipe[1] == pipe[2]) ? pipe[2] : held;
   endfunction : sdri_filt

   function automatic logic [DATA_W-1:0] sdri_default(input logic sel);
      return sel ? CODE_MID : CODE_ZERO; // R25
   endfunction : sdri_default

   // full restart: registers back to defaults, wait counter rearmed
   function automatic sdri_sys_t sdri_restart(
      input sdri_sys_t s,
      input logic      sel
   );
      sdri_sys_t r;
      r          = s;
      r.buf_code = sdri_default(sel); // R15
      r.act_code = sdri_default(sel); // R17
      r.mode_en  = MODE_RST;
      r.ready    = 1'b0;
      r.cnt      = '0;
      return r;
   endfunction : sdri_restart

   // ==========================================================
   // link domain: shifter
   // ==========================================================
   // cleared asynchronously while deselected, so a gated clock
   // needs no edge outside the frame to start clean
   sdri_shift_t lk_r;
   sdri_cap_t   cap_r;
   sdri_sys_t   q_r;
   sdri_sys_t   q_nxt;

   always_ff @(negedge link_sclk or posedge frame_sel_n) begin // R2
      if (frame_sel_n) begin
         lk_r <= '0; // R4 R7
      end else begin
         lk_r.bits <= {lk_r.bits[FRAME_BITS-3:0], serial_data_in}; // R1 R3
         if (lk_r.cnt != 5'(FRAME_BITS)) begin
            lk_r.cnt <= lk_r.cnt + 5'h01;
         end
      end
   end

   // ==========================================================
   // link domain: completed frame capture
   // ==========================================================
   // the word stays frozen from the 24th edge until the system side
   // has taken it and raised clr; extra edges beyond 24 are ignored
   always_ff @(negedge link_sclk or posedge q_r.clr) begin
      if (q_r.clr) begin
         cap_r <= '0;
      end else if (!cap_r.full && lk_r.cnt == LAST_EDGE) begin
         cap_r.full <= 1'b1; // R1
         cap_r.word <= {lk_r.bits, serial_data_in};
      end
   end

   // ==========================================================
   // system domain: next state
   // ==========================================================
   logic                  fsel_rise;
   logic                  pin_fall;
   logic                  in_frame_state;
   logic [ADDR_W-1:0]     addr;
   logic [DATA_W-1:0]     wdata;

   always_comb begin
      q_nxt             = q_r;
      q_nxt.frame_done  = 1'b0;
      q_nxt.frame_abort = 1'b0;

      q_nxt.fsel_pipe = {q_r.fsel_pipe[1:0], frame_sel_n};
      q_nxt.rstp_pipe = {q_r.rstp_pipe[1:0], hw_reset_n};
      q_nxt.sel_pipe  = {q_r.sel_pipe[1:0], reset_level_select};
      q_nxt.full_pipe = {q_r.full_pipe[1:0], cap_r.full};
      q_nxt.fsel_f    = sdri_filt(q_r.fsel_pipe, q_r.fsel_f);
      q_nxt.rstp_f    = sdri_filt(q_r.rstp_pipe, q_r.rstp_f);
      q_nxt.sel_f     = sdri_filt(q_r.sel_pipe, q_r.sel_f);
      q_nxt.full_f    = sdri_filt(q_r.full_pipe, q_r.full_f);

      fsel_rise      = !q_r.fsel_f && q_nxt.fsel_f;
      pin_fall       = q_r.rstp_f && !q_nxt.rstp_f;
      in_frame_state = (q_r.st == ST_HOLD) || (q_r.st == ST_RUN);
      addr           = cap_r.word[ADDR_MSB:ADDR_LSB];
      wdata          = cap_r.word[DATA_W-1:0]; // R8

      // release the capture clear once the link side shows empty
      if (q_r.clr && !q_r.full_f && !q_nxt.full_f) begin
         q_nxt.clr = 1'b0;
      end

      unique case (q_r.st)
         ST_INIT: begin
            if (q_r.cnt == SETTLE_CYC) begin
               q_nxt    = sdri_restart(q_nxt, q_nxt.sel_f); // R15
               q_nxt.st = ST_HOLD;
            end else begin
               q_nxt.cnt = q_r.cnt + 16'h0001;
            end
         end
         ST_PIN: begin
            if (q_nxt.rstp_f) begin
               q_nxt.st  = ST_HOLD;
               q_nxt.cnt = '0;
            end
         end
         ST_HOLD: begin
            // ready only flags the wait the host is meant to keep
            if (q_r.cnt == WAIT_LAST) begin
               q_nxt.st    = ST_RUN;
               q_nxt.ready = 1'b1;
            end else begin
               q_nxt.cnt = q_r.cnt + 16'h0001;
            end
         end
         ST_RUN: begin
            q_nxt.ready = 1'b1;
         end
         default: begin
            q_nxt.st  = ST_INIT;
            q_nxt.cnt = '0;
         end
      endcase

      // a frame only counts if the 24th edge was seen before the rise
      if (in_frame_state && fsel_rise) begin
         if (q_nxt.full_f && !q_r.clr) begin
            q_nxt.clr        = 1'b1;
            q_nxt.frame_done = 1'b1; // R5 R26
            unique case (addr)
               ADDR_UPDATE_MODE: begin
                  q_nxt.mode_en = wdata[MODE_EN_BIT]; // R13
               end
               ADDR_LOAD_RESTART: begin
                  if (wdata[KEY_MSB:KEY_LSB] == SOFT_RESET_KEY) begin
                     q_nxt    = sdri_restart(q_nxt, q_nxt.sel_f); // R21 R24
                     q_nxt.st = ST_HOLD;
                  end else if (wdata[LOAD_BIT] && q_r.mode_en) begin
                     q_nxt.act_code = q_r.buf_code; // R11 R12 R23
                  end
               end
               ADDR_OUTPUT_CODE: begin
                  q_nxt.buf_code = wdata; // R9 R14
                  if (!q_r.mode_en) begin
                     q_nxt.act_code = wdata; // R10
                  end
               end
               default: begin
                  q_nxt.mode_en = q_r.mode_en; // R22
               end
            endcase
         end else begin
            // nothing but the clear reaches the registers
            q_nxt.clr         = 1'b1;
            q_nxt.frame_abort = 1'b1; // R7
         end
      end

      // select level is taken at the moment the pin goes low
      if (pin_fall) begin
         q_nxt    = sdri_restart(q_nxt, q_nxt.sel_f); // R18 R20
         q_nxt.st = ST_PIN;
      end else if (!q_nxt.rstp_f) begin
         q_nxt.st    = ST_PIN;
         q_nxt.ready = 1'b0;
      end

      if (rst) begin
         q_nxt             = '0;
         q_nxt.st          = ST_INIT;
         q_nxt.fsel_pipe   = 3'h7;
         q_nxt.rstp_pipe   = 3'h7;
         q_nxt.fsel_f      = 1'b1;
         q_nxt.rstp_f      = 1'b1;
         q_nxt.clr         = 1'b1;
         q_nxt.buf_code    = CODE_ZERO;
         q_nxt.act_code    = CODE_ZERO;
         q_nxt.mode_en     = MODE_RST;
      end
   end

   // ==========================================================
   // system domain: state register
   // ==========================================================
   always_ff @(posedge clk_sys) begin
      q_r <= q_nxt;
   end

   // ==========================================================
   // outputs
   // ==========================================================
   assign code_out    = q_r.act_code;
   assign buffer_out  = q_r.buf_code;
   assign update_mode = q_r.mode_en;
   assign link_ready  = q_r.ready;
   assign frame_done  = q_r.frame_done;
   assign frame_abort = q_r.frame_abort;

endmodule : sdri_top

/* File: sdri_pkg.sv */
// package: constants and carriers for the serial code-register front end
package sdri_pkg;

   // ==========================================================
   // frame layout
   // ==========================================================
   localparam int          FRAME_BITS = 24;
   localparam int          CNT_W      = 5;
   localparam int          DATA_W     = 16;
   localparam int          ADDR_W     = 7;
   localparam int          WAIT_W     = 16;
   localparam int          WR_BIT     = 23;
   localparam int          ADDR_MSB   = 22;
   localparam int          ADDR_LSB   = 16;
   localparam logic [4:0]  LAST_EDGE  = 5'h17;

   // ==========================================================
   // register map
   // ==========================================================
   localparam logic [6:0]  ADDR_NO_OPERATION = 7'h00;
   localparam logic [6:0]  ADDR_UPDATE_MODE  = 7'h02;
   localparam logic [6:0]  ADDR_LOAD_RESTART = 7'h05;
   localparam logic [6:0]  ADDR_OUTPUT_CODE  = 7'h08;
   localparam int          MODE_EN_BIT       = 0;
   localparam int          LOAD_BIT          = 4;
   localparam int          KEY_MSB           = 3;
   localparam int          KEY_LSB           = 0;
   localparam logic [3:0]  SOFT_RESET_KEY    = 4'ha;
   localparam logic        MODE_RST          = 1'b0;
   localparam logic [15:0] CODE_ZERO         = 16'h0000;
   localparam logic [15:0] CODE_MID          = 16'h8000;

   // ==========================================================
   // timing
   // ==========================================================
   localparam int          SYS_CLK_HZ   = 20_000_000;
   localparam int          POR_WAIT_US  = 250;
   localparam int unsigned POR_WAIT_CYC =
      int'((longint'(POR_WAIT_US) * SYS_CLK_HZ + 999_999) / 1_000_000);
   localparam logic [15:0] SETTLE_CYC   = 16'h0004;

   // ==========================================================
   // carriers
   // ==========================================================
   typedef enum logic [3:0] {
      ST_INIT = 4'b0001,
      ST_PIN  = 4'b0010,
      ST_HOLD = 4'b0100,
      ST_RUN  = 4'b1000
   } sdri_state_t;

   typedef struct packed {
      logic [FRAME_BITS-2:0] bits;
      logic [CNT_W-1:0]      cnt;
   } sdri_shift_t;

   typedef struct packed {
      logic                  full;
      logic [FRAME_BITS-1:0] word;
   } sdri_cap_t;

   typedef struct packed {
      sdri_state_t       st;
      logic [WAIT_W-1:0] cnt;
      logic [2:0]        sel_pipe;
      logic [2:0]        rstp_pipe;
      logic [2:0]        fsel_pipe;
      logic [2:0]        full_pipe;
      logic              sel_f;
      logic              rstp_f;
      logic              fsel_f;
      logic              full_f;
      logic [DATA_W-1:0] buf_code;
      logic [DATA_W-1:0] act_code;
      logic              mode_en;
      logic              clr;
      logic              ready;
      logic              frame_done;
      logic              frame_abort;
   } sdri_sys_t;

endpackage : sdri_pkg

/* File: sdri_top_monitor.sv */
// checker: port relations of the serial code front end
module sdri_top_monitor
   import sdri_pkg::*;
#(
   parameter int unsigned POR_WAIT = 8
) (
   input wire logic              clk_sys,
   input wire logic              rst,
   input wire logic              link_sclk,
   input wire logic              frame_sel_n,
   input wire logic              serial_data_in,
   input wire logic              hw_reset_n,
   input wire logic              reset_level_select,
   input wire logic [DATA_W-1:0] code_out,
   input wire logic [DATA_W-1:0] buffer_out,
   input wire logic              update_mode,
   input wire logic              link_ready,
   input wire logic              frame_done,
   input wire logic              frame_abort
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   // ==========================================================
   // assertions
   // ==========================================================
   a_reset_clears: assert property (disable iff (1'b0) rst |=>
      code_out == CODE_ZERO && buffer_out == CODE_ZERO && !update_mode && !link_ready)
      else $error("outputs not cleared by reset");
   // a pin reset may answer by dropping ready instead of a pulse
   a_frame_answer: assert property ($rose(frame_sel_n) && link_ready && hw_reset_n
      |-> ##[1:6] (frame_done || frame_abort || !link_ready))
      else $error("frame end got no answer");
   a_pulse_excl: assert property (!(frame_done && frame_abort))
      else $error("done and abort together");
   a_done_single: assert property (frame_done |=> !frame_done)
      else $error("done pulse longer than one cycle");
   a_abort_keeps: assert property (frame_abort |-> $stable(code_out)
      && $stable(buffer_out) && $stable(update_mode))
      else $error("aborted frame changed state");
   a_async_copy: assert property (frame_done && !update_mode && $changed(buffer_out)
      |-> code_out == buffer_out)
      else $error("buffer not copied in immediate mode");
   a_sync_hold: assert property (frame_done && update_mode && $changed(buffer_out)
      |-> $stable(code_out))
      else $error("output moved without load trigger");
   a_quiet_outputs: assert property (hw_reset_n[*6] ##0 (link_ready && $past(link_ready)
      && !frame_done) |-> $stable(code_out) && $stable(buffer_out))
      else $error("output moved without a frame");
   // with the select level held steady from the pin fall on, the default follows that level
   a_hw_default: assert property (($fell(hw_reset_n) && $stable(reset_level_select))
      ##1 (!hw_reset_n && $stable(reset_level_select))[*5]
      |-> code_out == (reset_level_select ? CODE_MID : CODE_ZERO)
      && buffer_out == code_out && !update_mode && !link_ready)
      else $error("hardware reset default wrong");

   c_sync_write: cover property (frame_done && update_mode);
   c_abort: cover property (frame_abort);
   c_restart: cover property ($fell(link_ready) && hw_reset_n);
endmodule : sdri_top_monitor

/* File: sdri_host_model.sv */
// host model: drives gated 80 ns link frames
module sdri_host_model (
   output logic link_sclk,
   output logic frame_sel_n,
   output logic serial_data_in
);
   timeunit 1ns;
   timeprecision 100ps;
   localparam int HALF = 40;

   initial begin
      link_sclk = 1'b0;
      frame_sel_n = 1'b0;
      serial_data_in = 1'b0;
      // a clean rising select edge clears the shifter before the first frame
      #1;
      frame_sel_n = 1'b1;
   end

   // n below 24 makes a cut-short frame
   task automatic send(input logic [23:0] w, input int n);
      int i;
      #13;
      frame_sel_n = 1'b0;
      #(HALF);
      for (i = 0; i < n; i++) begin
         serial_data_in = w[23-i];
         link_sclk = 1'b1;
         #(HALF);
         link_sclk = 1'b0;
         #(HALF);
      end
      frame_sel_n = 1'b1;
      // released line must not keep its last value
      serial_data_in = ~serial_data_in;
   endtask : send

   // free-running clock and noise while deselected
   task automatic idle(input int n);
      repeat (n) begin
         serial_data_in = ~serial_data_in;
         link_sclk = 1'b1;
         #(HALF);
         link_sclk = 1'b0;
         #(HALF);
      end
   endtask : idle
endmodule : sdri_host_model

/* File: sdri_tb_top.sv */
// testbench: frame sequences against the code front end
module sdri_tb_top;
   import sdri_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;

   logic              clk_sys, rst, hw_reset_n, reset_level_select;
   logic              link_sclk, frame_sel_n, serial_data_in;
   logic [DATA_W-1:0] code_out, buffer_out;
   logic              update_mode, link_ready, frame_done, frame_abort;
   int                miscompares = 0;
   int                n_compared  = 0;

   sdri_host_model sdri_host_model_i (.link_sclk(link_sclk), .frame_sel_n(frame_sel_n),
      .serial_data_in(serial_data_in));
   sdri_top #(.POR_WAIT(8)) sdri_top_i (.clk_sys(clk_sys), .rst(rst),
      .link_sclk(link_sclk), .frame_sel_n(frame_sel_n), .serial_data_in(serial_data_in),
      .hw_reset_n(hw_reset_n), .reset_level_select(reset_level_select),
      .code_out(code_out), .buffer_out(buffer_out), .update_mode(update_mode),
      .link_ready(link_ready), .frame_done(frame_done), .frame_abort(frame_abort));

   // ==========================================================
   // helpers
   // ==========================================================
   task automatic wrap_up;
      $display("compared %0d miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : wrap_up

   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   task automatic regs(input logic [15:0] c, input logic [15:0] b, input logic m);
      chk("code_out", c, code_out);
      chk("buffer_out", b, buffer_out);
      chk("update_mode", {15'h0000, m}, {15'h0000, update_mode});
   endtask : regs

   task automatic wait_ready;
      int k;
      for (k = 0; k < 80 && link_ready !== 1'b1; k++) begin
         @(posedge clk_sys);
         #2;
      end
      if (k == 80) begin
         miscompares++;
         wrap_up();
      end
   endtask : wait_ready

   task automatic wr(input logic [6:0] a, input logic [15:0] d, input int n);
      int k;
      sdri_host_model_i.send({1'b1, a, d}, n);
      for (k = 0; k < 40; k++) begin
         @(posedge clk_sys);
         #2;
         if (frame_done === 1'b1 || frame_abort === 1'b1) break;
      end
      if (k == 40) begin
         miscompares++;
         wrap_up();
      end
      chk("frame_abort", {15'h0000, n < 24}, {15'h0000, frame_abort});
      repeat (6) @(posedge clk_sys);
   endtask : wr

   // ==========================================================
   // clock, watchdog and sequence
   // ==========================================================
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end

   initial begin
      repeat (100000) @(posedge clk_sys);
      miscompares++;
      wrap_up();
   end

   initial begin
      rst = 1'b1;
      hw_reset_n = 1'b1;
      reset_level_select = 1'b0;
      repeat (20) @(posedge clk_sys);
      #2 rst = 1'b0;
      wait_ready();
      regs(CODE_ZERO, CODE_ZERO, 1'b0);
      wr(ADDR_OUTPUT_CODE, 16'h1234, 24);
      regs(16'h1234, 16'h1234, 1'b0);
      wr(ADDR_NO_OPERATION, 16'hffff, 24);
      wr(7'h03, 16'h0001, 24);
      wr(ADDR_OUTPUT_CODE, 16'habcd, 23);
      sdri_host_model_i.idle(8);
      repeat (10) @(posedge clk_sys);
      regs(16'h1234, 16'h1234, 1'b0);
      wr(ADDR_UPDATE_MODE, 16'hfffe, 24);
      regs(16'h1234, 16'h1234, 1'b0);
      wr(ADDR_UPDATE_MODE, 16'h0001, 24);
      wr(ADDR_OUTPUT_CODE, 16'h5555, 24);
      regs(16'h1234, 16'h5555, 1'b1);
      wr(ADDR_LOAD_RESTART, 16'h0010, 24);
      regs(16'h5555, 16'h5555, 1'b1);
      wr(ADDR_OUTPUT_CODE, 16'hffff, 24);
      regs(16'h5555, 16'hffff, 1'b1);
      wr(ADDR_LOAD_RESTART, 16'h0010, 24);
      regs(16'hffff, 16'hffff, 1'b1);
      @(posedge clk_sys);
      #2 reset_level_select = 1'b1;
      sdri_host_model_i.send({1'b1, ADDR_LOAD_RESTART, 16'h001a}, 24);
      repeat (12) @(posedge clk_sys);
      wait_ready();
      regs(CODE_MID, CODE_MID, 1'b0);
      wr(ADDR_OUTPUT_CODE, 16'h4321, 24);
      @(posedge clk_sys);
      #2 reset_level_select = 1'b0;
      @(posedge clk_sys);
      #2 hw_reset_n = 1'b0;
      repeat (6) @(posedge clk_sys);
      #2 regs(CODE_ZERO, CODE_ZERO, 1'b0);
      reset_level_select = 1'b1;
      repeat (6) @(posedge clk_sys);
      #2 regs(CODE_ZERO, CODE_ZERO, 1'b0);
      hw_reset_n = 1'b1;
      wait_ready();
      regs(CODE_ZERO, CODE_ZERO, 1'b0);
      wrap_up();
   end
endmodule : sdri_tb_top

bind sdri_top sdri_top_monitor #(.POR_WAIT(POR_WAIT)) sdri_top_monitor_i (
   .clk_sys(clk_sys), .rst(rst), .link_sclk(link_sclk), .frame_sel_n(frame_sel_n),
   .serial_data_in(serial_data_in), .hw_reset_n(hw_reset_n),
   .reset_level_select(reset_level_select), .code_out(code_out), .buffer_out(buffer_out),
   .update_mode(update_mode), .link_ready(link_ready), .frame_done(frame_done),
   .frame_abort(frame_abort));
